// *** rtl/sibd_exec.sv ***
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/10ps
// ==========================================================
// skip / io / branch execution unit
module sibd_exec (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic exec,
  input wire sibd_pkg::sibd_instr_t instr,
  input wire sibd_pkg::sibd_core_t core,
  input wire sibd_pkg::sibd_bit_wr_t carry_in,
  input wire logic occurrence_event,
  input wire logic irq_take,
  input wire logic [sibd_pkg::PC_W-1:0] irq_vector,
  input wire logic [3:0] port_e_pin,
  input wire logic [3:0] port_g_pin,
  input wire logic [3:0] port_l_pin,
  input wire logic port_d_pin,
  input wire sibd_pkg::sibd_bus_req_t bus_req,
  output logic [sibd_pkg::BUS_DATA_W-1:0] bus_rdata,
  output sibd_pkg::sibd_nib_wr_t acc_wr,
  output sibd_pkg::sibd_nib_wr_t mem_wr,
  output logic carry_flag,
  output logic skip_flag,
  output logic interrupt_enable_flag,
  output logic [sibd_pkg::PC_W-1:0] pc,
  output logic [sibd_pkg::OCC_LATCH_W-1:0] occurrence_latch,
  output logic [sibd_pkg::OCC_CTRL_W-1:0] occurrence_control_bits,
  output logic [3:0] port_f,
  output logic [3:0] port_g,
  output logic [3:0] port_h,
  output logic [3:0] port_j,
  output logic [3:0] port_k,
  output logic [3:0] port_l,
  output logic [2:0] port_m,
  output logic port_d_out,
  output logic port_d_oe_n,
  output logic [sibd_pkg::VDP_NUM-1:0][sibd_pkg::VDP_W-1:0] voltage_pwm_out,
  output logic [sibd_pkg::DA_W-1:0] da_latch
);

  typedef struct packed {
    logic carry;
    logic skip;
    logic saved_skip_state;
    logic ie;
    logic occurrence_flipflop;
    logic [sibd_pkg::OCC_CTRL_W-1:0] occ_ctrl;
    logic [sibd_pkg::OCC_LATCH_W-1:0] occ_latch;
    logic silence_flag;
    logic [sibd_pkg::VDP_NUM-1:0][sibd_pkg::VDP_W-1:0] voltage_pwm_latch;
    logic [sibd_pkg::VDP_NUM-1:0][sibd_pkg::VDP_W-1:0] vdp_out;
    logic [sibd_pkg::DA_W-1:0] da;
    logic [sibd_pkg::PC_W-1:0] pc;
    logic [sibd_pkg::STACK_DEPTH-1:0][sibd_pkg::PC_W-1:0] stack;
    logic [sibd_pkg::SP_W-1:0] sp;
    sibd_pkg::sibd_nib_wr_t acc_wr;
    sibd_pkg::sibd_nib_wr_t mem_wr;
    logic d_oe_n;
    logic [sibd_pkg::BUS_DATA_W-1:0] ctrl;
    logic [sibd_pkg::BUS_DATA_W-1:0] rdata;
  } sibd_state_t;

  sibd_state_t st_ff;
  sibd_state_t nxt_st;

  logic [sibd_pkg::SYNC_W-1:0] pins_sync;
  logic [sibd_pkg::NIB_PORTS-1:0] port_ld;
  logic m_ld;
  logic d_ld;
  logic [sibd_pkg::NIB_PORTS-1:0][3:0] port_q;
  logic run;
  logic occ_clr;
  logic [1:0] bit_sel;
  logic [3:0] mem_mod;
  logic [3:0] imm_nib;
  logic [1:0] vdp_sel;
  logic [sibd_pkg::SP_W-1:0] sp_dec;
  logic [sibd_pkg::PC_W-1:0] page_target;
  logic [sibd_pkg::PC_W-1:0] stack_top;

  // ==========================================================
  // pin inputs
  sibd_sync #(
    .W(sibd_pkg::SYNC_W)
  ) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in({port_d_pin, port_l_pin, port_g_pin, port_e_pin}),
    .sync_out(pins_sync)
  );

  // ==========================================================
  // output ports
  for (genvar i = 0; i < sibd_pkg::NIB_PORTS; i++) begin : g_port
    sibd_port_reg #(
      .W(4),
      .RST(sibd_pkg::PORT_RST[i*4 +: 4])
    ) u_port (
      .clock(clock),
      .reset_n(reset_n),
      .load(port_ld[i]),
      .data(core.acc),
      .q(port_q[i])
    );
  end

  sibd_port_reg #(
    .W(3),
    .RST(sibd_pkg::PORT_M_RST)
  ) u_port_m (
    .clock(clock),
    .reset_n(reset_n),
    .load(m_ld),
    .data(core.acc[2:0]),
    .q(port_m)
  );

  sibd_port_reg #(
    .W(1),
    .RST(sibd_pkg::PORT_D_RST)
  ) u_port_d (
    .clock(clock),
    .reset_n(reset_n),
    .load(d_ld),
    .data(core.acc[3]),
    .q(port_d_out)
  );

  // ==========================================================
  // execution
  always_comb begin
    nxt_st = st_ff;
    port_ld = '0;
    m_ld = 1'b0;
    d_ld = 1'b0;
    occ_clr = 1'b0;
    run = exec && !st_ff.skip;
    bit_sel = instr.imm[1:0];
    imm_nib = instr.imm[3:0];
    vdp_sel = instr.imm[1:0];
    mem_mod = core.mem;
    sp_dec = st_ff.sp - 2'h1;
    stack_top = st_ff.stack[sp_dec];
    page_target = {instr.next_pc[sibd_pkg::PC_W-1], instr.imm[11:0]};
    nxt_st.acc_wr.en = 1'b0;
    nxt_st.mem_wr.en = 1'b0;
    if (carry_in.en) begin
      nxt_st.carry = carry_in.data;
    end
    if (exec && st_ff.skip) begin
      // fetched and discarded in the same slot, so timing is unchanged
      nxt_st.skip = 1'b0;
      nxt_st.pc = instr.next_pc;
    end else if (run) begin
      nxt_st.skip = 1'b0;
      nxt_st.pc = instr.next_pc;
      unique case (instr.op)
        sibd_pkg::OP_NOP: begin
        end
        sibd_pkg::OP_INVERT_CARRY: begin
          nxt_st.carry = !st_ff.carry;
        end
        sibd_pkg::OP_SKIP_IF_CARRY_CLEAR: begin
          nxt_st.skip = !st_ff.carry;
        end
        sibd_pkg::OP_SKIP_IF_CARRY_SET: begin
          nxt_st.skip = st_ff.carry;
        end
        sibd_pkg::OP_SET_MEMORY_BIT: begin
          mem_mod[bit_sel] = 1'b1;
          nxt_st.mem_wr.en = 1'b1;
          nxt_st.mem_wr.data = mem_mod;
        end
        sibd_pkg::OP_CLEAR_MEMORY_BIT: begin
          mem_mod[bit_sel] = 1'b0;
          nxt_st.mem_wr.en = 1'b1;
          nxt_st.mem_wr.data = mem_mod;
        end
        sibd_pkg::OP_SKIP_IF_BIT_CLEAR: begin
          nxt_st.skip = !core.mem[bit_sel];
        end
        sibd_pkg::OP_SKIP_IF_BIT_SET: begin
          nxt_st.skip = core.mem[bit_sel];
        end
        sibd_pkg::OP_SKIP_IF_ACC_EQUALS_IMM: begin
          nxt_st.skip = (core.acc == imm_nib);
        end
        sibd_pkg::OP_SKIP_IF_ACC_DIFFERS_IMM: begin
          nxt_st.skip = (core.acc != imm_nib);
        end
        sibd_pkg::OP_SKIP_IF_ACC_EQUALS_MEMORY: begin
          nxt_st.skip = (core.acc == core.mem);
        end
        sibd_pkg::OP_SKIP_IF_ACC_DIFFERS_MEMORY: begin
          nxt_st.skip = (core.acc != core.mem);
        end
        sibd_pkg::OP_INTERRUPT_DISABLE: begin
          nxt_st.ie = 1'b0;
        end
        sibd_pkg::OP_INTERRUPT_ENABLE: begin
          nxt_st.ie = 1'b1;
        end
        sibd_pkg::OP_READ_OCCURRENCE_FLAG: begin
          nxt_st.acc_wr.en = 1'b1;
          nxt_st.acc_wr.data = {3'h0, st_ff.occurrence_flipflop};
          occ_clr = 1'b1;
        end
        sibd_pkg::OP_READ_OCCURRENCE_CONTROL: begin
          nxt_st.acc_wr.en = 1'b1;
          nxt_st.acc_wr.data = {2'h0, st_ff.occ_ctrl[1:0]};
        end
        sibd_pkg::OP_WRITE_OCCURRENCE_CONTROL: begin
          nxt_st.occ_ctrl = core.acc[2:0];
        end
        sibd_pkg::OP_WRITE_OCCURRENCE_LATCH_LOW: begin
          nxt_st.occ_latch[3:0] = core.acc;
        end
        sibd_pkg::OP_WRITE_OCCURRENCE_LATCH_HIGH: begin
          nxt_st.occ_latch[7:4] = core.acc;
        end
        sibd_pkg::OP_SKIP_IF_OCCURRENCE_SET: begin
          nxt_st.skip = st_ff.occurrence_flipflop;
          occ_clr = 1'b1;
        end
        sibd_pkg::OP_SKIP_IF_OCCURRENCE_CLEAR: begin
          nxt_st.skip = !st_ff.occurrence_flipflop;
          occ_clr = 1'b1;
        end
        sibd_pkg::OP_OUTPUT_MSB_TO_PORT_D: begin
          d_ld = 1'b1;
          // port d leaves its input state once written
          nxt_st.d_oe_n = 1'b0;
        end
        sibd_pkg::OP_OUTPUT_PORT_F: begin
          port_ld[sibd_pkg::PORT_F] = 1'b1;
        end
        sibd_pkg::OP_OUTPUT_PORT_G: begin
          port_ld[sibd_pkg::PORT_G] = 1'b1;
        end
        sibd_pkg::OP_OUTPUT_PORT_H: begin
          port_ld[sibd_pkg::PORT_H] = 1'b1;
        end
        sibd_pkg::OP_OUTPUT_PORT_J: begin
          port_ld[sibd_pkg::PORT_J] = 1'b1;
        end
        sibd_pkg::OP_OUTPUT_PORT_K: begin
          port_ld[sibd_pkg::PORT_K] = 1'b1;
        end
        sibd_pkg::OP_OUTPUT_PORT_L: begin
          port_ld[sibd_pkg::PORT_L] = 1'b1;
        end
        sibd_pkg::OP_OUTPUT_LOW3_TO_PORT_M: begin
          m_ld = 1'b1;
        end
        sibd_pkg::OP_INPUT_PORT_E: begin
          nxt_st.acc_wr.en = 1'b1;
          nxt_st.acc_wr.data = pins_sync[sibd_pkg::SYNC_E_LSB +: 4];
        end
        sibd_pkg::OP_INPUT_PORT_G: begin
          nxt_st.acc_wr.en = 1'b1;
          nxt_st.acc_wr.data = pins_sync[sibd_pkg::SYNC_G_LSB +: 4];
        end
        sibd_pkg::OP_INPUT_PORT_L: begin
          nxt_st.acc_wr.en = 1'b1;
          nxt_st.acc_wr.data = pins_sync[sibd_pkg::SYNC_L_LSB +: 4];
        end
        sibd_pkg::OP_INPUT_PORT_D_TO_CARRY: begin
          nxt_st.carry = pins_sync[sibd_pkg::SYNC_D_BIT];
        end
        sibd_pkg::OP_LOAD_VOLTAGE_PWM: begin
          // selector 3 has no latch and is ignored
          if (vdp_sel != 2'h3) begin
            nxt_st.voltage_pwm_latch[vdp_sel] = {core.reg_b[2:0], core.acc};
          end
        end
        sibd_pkg::OP_LOAD_DA_LATCH: begin
          nxt_st.da = core.row0[sibd_pkg::DA_W-1:0];
        end
        sibd_pkg::OP_SILENCE_SET: begin
          nxt_st.silence_flag = 1'b1;
        end
        sibd_pkg::OP_SILENCE_CANCEL: begin
          nxt_st.silence_flag = 1'b0;
        end
        sibd_pkg::OP_PAGE_JUMP: begin
          nxt_st.pc = page_target;
        end
        sibd_pkg::OP_LONG_JUMP: begin
          nxt_st.pc = instr.imm;
        end
        sibd_pkg::OP_PAGE_CALL: begin
          nxt_st.stack[st_ff.sp] = instr.next_pc;
          nxt_st.sp = st_ff.sp + 2'h1;
          nxt_st.pc = page_target;
        end
        sibd_pkg::OP_LONG_CALL: begin
          nxt_st.stack[st_ff.sp] = instr.next_pc;
          nxt_st.sp = st_ff.sp + 2'h1;
          nxt_st.pc = instr.imm;
        end
        sibd_pkg::OP_RETURN_SUBROUTINE: begin
          nxt_st.sp = sp_dec;
          nxt_st.pc = stack_top;
        end
        sibd_pkg::OP_RETURN_FROM_INTERRUPT: begin
          nxt_st.sp = sp_dec;
          nxt_st.pc = stack_top;
          nxt_st.skip = st_ff.saved_skip_state;
        end
        sibd_pkg::OP_RETURN_AND_SKIP: begin
          nxt_st.sp = sp_dec;
          nxt_st.pc = stack_top;
          nxt_st.skip = 1'b1;
        end
        sibd_pkg::OP_FORCED_SKIP: begin
          nxt_st.skip = 1'b1;
        end
        default: begin
        end
      endcase
    end else if (irq_take) begin
      // entry only between instructions; the core stops requesting it then
      nxt_st.stack[st_ff.sp] = st_ff.pc;
      nxt_st.sp = st_ff.sp + 2'h1;
      nxt_st.pc = irq_vector;
      nxt_st.saved_skip_state = st_ff.skip;
      nxt_st.skip = 1'b0;
      nxt_st.ie = 1'b0;
    end
    // a new occurrence in the clearing cycle is kept
    nxt_st.occurrence_flipflop = (st_ff.occurrence_flipflop && !occ_clr) ||
                                 (occurrence_event && st_ff.ctrl[sibd_pkg::CTRL_OCC_EN]);
    for (int v = 0; v < sibd_pkg::VDP_NUM; v++) begin
      nxt_st.vdp_out[v] = st_ff.silence_flag ? '0 : st_ff.voltage_pwm_latch[v];
    end
    // ========================================================
    // register port
    if (bus_req.wr && bus_req.addr == sibd_pkg::REG_CTRL) begin
      nxt_st.ctrl = {15'h0000, bus_req.wdata[sibd_pkg::CTRL_OCC_EN]};
    end
    nxt_st.rdata = '0;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        sibd_pkg::REG_CTRL: nxt_st.rdata = st_ff.ctrl;
        sibd_pkg::REG_STATUS: begin
          nxt_st.rdata[sibd_pkg::ST_CARRY] = st_ff.carry;
          nxt_st.rdata[sibd_pkg::ST_SKIP] = st_ff.skip;
          nxt_st.rdata[sibd_pkg::ST_SAVED_SKIP] = st_ff.saved_skip_state;
          nxt_st.rdata[sibd_pkg::ST_IE] = st_ff.ie;
          nxt_st.rdata[sibd_pkg::ST_OCC] = st_ff.occurrence_flipflop;
          nxt_st.rdata[sibd_pkg::ST_MUTE] = st_ff.silence_flag;
          nxt_st.rdata[sibd_pkg::ST_D_OE_N] = st_ff.d_oe_n;
        end
        sibd_pkg::REG_OCC: nxt_st.rdata = {5'h00, st_ff.occ_ctrl, st_ff.occ_latch};
        sibd_pkg::REG_DA: nxt_st.rdata = {1'b0, st_ff.da};
        sibd_pkg::REG_PC: nxt_st.rdata = {3'h0, st_ff.pc};
        default: nxt_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
      st_ff.d_oe_n <= 1'b1;
      st_ff.ctrl <= sibd_pkg::CTRL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs
  assign bus_rdata = st_ff.rdata;
  assign acc_wr = st_ff.acc_wr;
  assign mem_wr = st_ff.mem_wr;
  assign carry_flag = st_ff.carry;
  assign skip_flag = st_ff.skip;
  assign interrupt_enable_flag = st_ff.ie;
  assign pc = st_ff.pc;
  assign occurrence_latch = st_ff.occ_latch;
  assign occurrence_control_bits = st_ff.occ_ctrl;
  assign port_f = port_q[sibd_pkg::PORT_F];
  assign port_g = port_q[sibd_pkg::PORT_G];
  assign port_h = port_q[sibd_pkg::PORT_H];
  assign port_j = port_q[sibd_pkg::PORT_J];
  assign port_k = port_q[sibd_pkg::PORT_K];
  assign port_l = port_q[sibd_pkg::PORT_L];
  assign port_d_oe_n = st_ff.d_oe_n;
  assign voltage_pwm_out = st_ff.vdp_out;
  assign da_latch = st_ff.da;

endmodule

// *** rtl/sibd_pkg.sv ***
package sibd_pkg;

  // ==========================================================
  // widths
  localparam int PC_W = 13;
  localparam int NIB_W = 4;
  localparam int VDP_W = 7;
  localparam int VDP_NUM = 3;
  localparam int DA_W = 15;
  localparam int OCC_LATCH_W = 8;
  localparam int OCC_CTRL_W = 3;
  localparam int STACK_DEPTH = 4;
  localparam int SP_W = 2;
  localparam int BUS_ADDR_W = 8;
  localparam int BUS_DATA_W = 16;
  localparam int SYNC_W = 13;
  localparam int NIB_PORTS = 6;

  // ==========================================================
  // nibble output port indices
  localparam int PORT_F = 0;
  localparam int PORT_G = 1;
  localparam int PORT_H = 2;
  localparam int PORT_J = 3;
  localparam int PORT_K = 4;
  localparam int PORT_L = 5;

  // ==========================================================
  // synchronised pin vector layout
  localparam int SYNC_E_LSB = 0;
  localparam int SYNC_G_LSB = 4;
  localparam int SYNC_L_LSB = 8;
  localparam int SYNC_D_BIT = 12;

  // ==========================================================
  // reset values
  localparam logic [NIB_PORTS*NIB_W-1:0] PORT_RST = 24'hFF_FFF0;
  localparam logic [2:0] PORT_M_RST = 3'h7;
  localparam logic PORT_D_RST = 1'b0;
  localparam logic [BUS_DATA_W-1:0] CTRL_RST = 16'h0001;

  // ==========================================================
  // register offsets
  localparam logic [BUS_ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [BUS_ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [BUS_ADDR_W-1:0] REG_OCC = 8'h08;
  localparam logic [BUS_ADDR_W-1:0] REG_DA = 8'h0C;
  localparam logic [BUS_ADDR_W-1:0] REG_PC = 8'h10;

  // status and control field positions
  localparam int ST_CARRY = 0;
  localparam int ST_SKIP = 1;
  localparam int ST_SAVED_SKIP = 2;
  localparam int ST_IE = 3;
  localparam int ST_OCC = 4;
  localparam int ST_MUTE = 5;
  localparam int ST_D_OE_N = 6;
  localparam int CTRL_OCC_EN = 0;

  // ==========================================================
  // operations of this group
  typedef enum logic [5:0] {
    OP_NOP, OP_INVERT_CARRY, OP_SKIP_IF_CARRY_CLEAR, OP_SKIP_IF_CARRY_SET,
    OP_SET_MEMORY_BIT, OP_CLEAR_MEMORY_BIT, OP_SKIP_IF_BIT_CLEAR, OP_SKIP_IF_BIT_SET,
    OP_SKIP_IF_ACC_EQUALS_IMM, OP_SKIP_IF_ACC_DIFFERS_IMM,
    OP_SKIP_IF_ACC_EQUALS_MEMORY, OP_SKIP_IF_ACC_DIFFERS_MEMORY,
    OP_INTERRUPT_DISABLE, OP_INTERRUPT_ENABLE,
    OP_READ_OCCURRENCE_FLAG, OP_READ_OCCURRENCE_CONTROL, OP_WRITE_OCCURRENCE_CONTROL,
    OP_WRITE_OCCURRENCE_LATCH_LOW, OP_WRITE_OCCURRENCE_LATCH_HIGH,
    OP_SKIP_IF_OCCURRENCE_SET, OP_SKIP_IF_OCCURRENCE_CLEAR,
    OP_OUTPUT_MSB_TO_PORT_D, OP_OUTPUT_PORT_F, OP_OUTPUT_PORT_G, OP_OUTPUT_PORT_H,
    OP_OUTPUT_PORT_J, OP_OUTPUT_PORT_K, OP_OUTPUT_PORT_L, OP_OUTPUT_LOW3_TO_PORT_M,
    OP_INPUT_PORT_E, OP_INPUT_PORT_G, OP_INPUT_PORT_L, OP_INPUT_PORT_D_TO_CARRY,
    OP_LOAD_VOLTAGE_PWM, OP_LOAD_DA_LATCH, OP_SILENCE_SET, OP_SILENCE_CANCEL,
    OP_PAGE_JUMP, OP_PAGE_CALL, OP_LONG_JUMP, OP_LONG_CALL,
    OP_RETURN_SUBROUTINE, OP_RETURN_FROM_INTERRUPT, OP_RETURN_AND_SKIP, OP_FORCED_SKIP
  } sibd_op_t;

  typedef struct packed {
    sibd_op_t op;
    logic [PC_W-1:0] imm;
    logic [PC_W-1:0] next_pc;
  } sibd_instr_t;

  typedef struct packed {
    logic [NIB_W-1:0] acc;
    logic [NIB_W-1:0] reg_b;
    logic [NIB_W-1:0] mem;
    logic [4*NIB_W-1:0] row0;
  } sibd_core_t;

  typedef struct packed {
    logic en;
    logic [NIB_W-1:0] data;
  } sibd_nib_wr_t;

  typedef struct packed {
    logic en;
    logic data;
  } sibd_bit_wr_t;

  typedef struct packed {
    logic [BUS_ADDR_W-1:0] addr;
    logic [BUS_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } sibd_bus_req_t;

endpackage

// *** rtl/sibd_sync.sv ***
`timescale 1ns/10ps
// ==========================================================
// two-stage pin synchroniser
module sibd_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sibd_sync_state_t;

  sibd_sync_state_t st_ff;
  sibd_sync_state_t nxt_st;

  always_comb begin
    nxt_st.meta = async_in;
    nxt_st.stable = st_ff.meta;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.stable;

endmodule

// *** rtl/sibd_port_reg.sv ***
`timescale 1ns/10ps
// ==========================================================
// output port latch
module sibd_port_reg #(
  parameter int W = 4,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [W-1:0] data,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] val;
  } sibd_port_state_t;

  sibd_port_state_t st_ff;
  sibd_port_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (load) begin
      nxt_st.val = data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff.val <= RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.val;

endmodule

// *** dv/sibd_exec_checker.sv ***
`timescale 1ns/10ps
module sibd_exec_checker (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic exec,
  input wire sibd_pkg::sibd_instr_t instr,
  input wire sibd_pkg::sibd_core_t core,
  input wire logic skip_flag,
  input wire logic carry_flag,
  input wire logic interrupt_enable_flag,
  input wire logic [sibd_pkg::PC_W-1:0] pc,
  input wire sibd_pkg::sibd_nib_wr_t acc_wr,
  input wire logic [2:0] port_m
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // instruction that really executes (not a discarded one)
  sequence s_run(sibd_pkg::sibd_op_t o);
    exec && !skip_flag && instr.op == o;
  endsequence
  a_invert_carry: assert property (s_run(sibd_pkg::OP_INVERT_CARRY) |=> carry_flag != $past(carry_flag))
    else $error("carry not inverted");
  a_skip_eq_imm: assert property (s_run(sibd_pkg::OP_SKIP_IF_ACC_EQUALS_IMM) ##0 core.acc == instr.imm[3:0]
    |=> skip_flag)
    else $error("equal immediate did not skip");
  a_skip_drop: assert property (exec && skip_flag |=> !skip_flag && !acc_wr.en)
    else $error("skipped instruction had an effect");
  a_ie_clear: assert property (s_run(sibd_pkg::OP_INTERRUPT_DISABLE) |=> !interrupt_enable_flag)
    else $error("interrupt enable not cleared");
  a_forced_skip: assert property (s_run(sibd_pkg::OP_FORCED_SKIP) |=> skip_flag)
    else $error("forced skip missing");
  a_long_jump: assert property (s_run(sibd_pkg::OP_LONG_JUMP) |=> pc == $past(instr.imm))
    else $error("long jump target wrong");
  a_port_m_low3: assert property (s_run(sibd_pkg::OP_OUTPUT_LOW3_TO_PORT_M)
    |=> port_m == $past(core.acc[2:0]))
    else $error("port m value wrong");
  a_flag_read: assert property (s_run(sibd_pkg::OP_READ_OCCURRENCE_FLAG)
    |=> acc_wr.en && acc_wr.data[3:1] == 3'h0)
    else $error("flag read format wrong");
  a_ctrl_read: assert property (s_run(sibd_pkg::OP_READ_OCCURRENCE_CONTROL)
    |=> acc_wr.en && acc_wr.data[3:2] == 2'h0)
    else $error("control read format wrong");
endmodule
bind sibd_exec sibd_exec_checker u_chk (.clock, .reset_n, .exec, .instr, .core, .skip_flag, .carry_flag,
  .interrupt_enable_flag, .pc, .acc_wr, .port_m);

// *** dv/sibd_exec_bench.sv ***
`timescale 1ns/10ps
module sibd_exec_bench;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic exec = 1'b0;
  sibd_pkg::sibd_instr_t instr = '0;
  sibd_pkg::sibd_core_t core = '0;
  logic occurrence_event = 1'b0;
  logic [3:0] port_e_pin = 4'h0, port_g_pin = 4'h0, port_l_pin = 4'h0;
  logic irq_take = 1'b0;
  logic port_d_pin = 1'b0;
  sibd_pkg::sibd_bus_req_t bus_req = '0;
  logic [15:0] bus_rdata;
  sibd_pkg::sibd_nib_wr_t acc_wr, mem_wr;
  logic carry_flag, skip_flag, interrupt_enable_flag, port_d_out, port_d_oe_n;
  logic [12:0] pc;
  logic [7:0] occurrence_latch;
  logic [2:0] occurrence_control_bits, port_m;
  logic [3:0] port_f;
  logic [2:0][6:0] voltage_pwm_out;
  logic [14:0] da_latch;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  sibd_exec DUT (.clock, .reset_n, .exec, .instr, .core, .carry_in('0), .occurrence_event, .irq_take,
    .irq_vector('0), .port_e_pin, .port_g_pin, .port_l_pin, .port_d_pin, .bus_req, .bus_rdata,
    .acc_wr, .mem_wr, .carry_flag, .skip_flag, .interrupt_enable_flag, .pc, .occurrence_latch,
    .occurrence_control_bits, .port_f, .port_g(), .port_h(), .port_j(), .port_k(), .port_l(), .port_m,
    .port_d_out, .port_d_oe_n, .voltage_pwm_out, .da_latch);
  always #2 clock = ~clock;
  // ==========================================================
  // helpers
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // generous ceiling, the run needs about 150 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp)
      $display("Error %0t: got %h want %h", $time, got, exp);
    if (got !== exp)
      miscompares++;
  endtask
  // every op carries the same following address
  task automatic run(sibd_pkg::sibd_op_t op, logic [12:0] imm);
    @(posedge clock);
    instr <= '{op, imm, 13'h0040};
    exec <= 1'b1;
    @(posedge clock);
    exec <= 1'b0;
    #1;
  endtask
  task automatic ck();
    @(posedge clock);
    #1;
  endtask
  task automatic ev();
    @(posedge clock);
    occurrence_event <= 1'b1;
    @(posedge clock);
    occurrence_event <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] exp);
    @(posedge clock);
    bus_req <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clock);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
    #1;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_carry();
    run(sibd_pkg::OP_INVERT_CARRY, 13'h0);
    chk(carry_flag, 1'b1);
    run(sibd_pkg::OP_SKIP_IF_CARRY_SET, 13'h0);
    chk(skip_flag, 1'b1);
    run(sibd_pkg::OP_INVERT_CARRY, 13'h0);
    chk({skip_flag, carry_flag}, 2'h1);
    run(sibd_pkg::OP_SKIP_IF_CARRY_CLEAR, 13'h0);
    chk(skip_flag, 1'b0);
    $display("carry done");
  endtask
  task automatic t_cmp();
    for (int n = 0; n < 16; n += 15) begin
      @(posedge clock) core <= '{n[3:0], 4'h0, n[3:0], 16'h0};
      run(sibd_pkg::OP_SKIP_IF_ACC_EQUALS_IMM, 13'(n));
      chk(skip_flag, 1'b1);
      run(sibd_pkg::OP_SKIP_IF_ACC_EQUALS_MEMORY, 13'h0);
      chk(skip_flag, 1'b0);
      run(sibd_pkg::OP_SKIP_IF_ACC_EQUALS_MEMORY, 13'h0);
      chk(skip_flag, 1'b1);
      run(sibd_pkg::OP_SKIP_IF_ACC_DIFFERS_IMM, 13'(n ^ 1));
      run(sibd_pkg::OP_SKIP_IF_ACC_DIFFERS_IMM, 13'(n ^ 1));
      chk(skip_flag, 1'b1);
      run(sibd_pkg::OP_NOP, 13'h0);
      run(sibd_pkg::OP_SKIP_IF_ACC_DIFFERS_MEMORY, 13'h0);
      chk(skip_flag, 1'b0);
    end
    @(posedge clock) core <= '{4'h0, 4'h0, 4'hB, 16'h0};
    run(sibd_pkg::OP_SET_MEMORY_BIT, 13'h2);
    chk(mem_wr, 5'h1F);
    run(sibd_pkg::OP_CLEAR_MEMORY_BIT, 13'h0);
    chk(mem_wr, 5'h1A);
    run(sibd_pkg::OP_SKIP_IF_BIT_CLEAR, 13'h2);
    chk(skip_flag, 1'b1);
    run(sibd_pkg::OP_NOP, 13'h0);
    run(sibd_pkg::OP_SKIP_IF_BIT_SET, 13'h1);
    chk(skip_flag, 1'b1);
    run(sibd_pkg::OP_NOP, 13'h0);
    $display("compare done");
  endtask
  task automatic t_occ();
    ev();
    run(sibd_pkg::OP_READ_OCCURRENCE_FLAG, 13'h0);
    chk(acc_wr, 5'h11);
    run(sibd_pkg::OP_READ_OCCURRENCE_FLAG, 13'h0);
    chk(acc_wr, 5'h10);
    wr(sibd_pkg::REG_CTRL, 16'h0);
    ev();
    rd(sibd_pkg::REG_STATUS, 16'h0041);
    wr(sibd_pkg::REG_CTRL, 16'h1);
    ev();
    run(sibd_pkg::OP_SKIP_IF_OCCURRENCE_SET, 13'h0);
    chk(skip_flag, 1'b1);
    run(sibd_pkg::OP_NOP, 13'h0);
    @(posedge clock) core <= '{4'h7, 4'h0, 4'h0, 16'h0};
    run(sibd_pkg::OP_READ_OCCURRENCE_FLAG, 13'h0);
    chk(acc_wr, 5'h10);
    run(sibd_pkg::OP_SKIP_IF_OCCURRENCE_CLEAR, 13'h0);
    chk(skip_flag, 1'b1);
    run(sibd_pkg::OP_NOP, 13'h0);
    run(sibd_pkg::OP_WRITE_OCCURRENCE_CONTROL, 13'h0);
    chk(occurrence_control_bits, 3'h7);
    run(sibd_pkg::OP_READ_OCCURRENCE_CONTROL, 13'h0);
    chk(acc_wr, 5'h13);
    @(posedge clock) core.acc <= 4'h5;
    run(sibd_pkg::OP_WRITE_OCCURRENCE_LATCH_LOW, 13'h0);
    @(posedge clock) core.acc <= 4'hA;
    run(sibd_pkg::OP_WRITE_OCCURRENCE_LATCH_HIGH, 13'h0);
    chk(occurrence_latch, 8'hA5);
    $display("occurrence done");
  endtask
  task automatic t_io();
    @(posedge clock) {port_e_pin, port_g_pin, port_l_pin} <= 12'h6C3;
    @(posedge clock) core <= '{4'h9, 4'hD, 4'h0, 16'hFABC};
    run(sibd_pkg::OP_OUTPUT_PORT_F, 13'h0);
    chk(port_f, 4'h9);
    run(sibd_pkg::OP_OUTPUT_LOW3_TO_PORT_M, 13'h0);
    chk(port_m, 3'h1);
    run(sibd_pkg::OP_OUTPUT_MSB_TO_PORT_D, 13'h0);
    chk({port_d_oe_n, port_d_out}, 2'h1);
    run(sibd_pkg::OP_INPUT_PORT_E, 13'h0);
    chk(acc_wr, 5'h16);
    run(sibd_pkg::OP_INPUT_PORT_G, 13'h0);
    chk(acc_wr, 5'h1C);
    run(sibd_pkg::OP_INPUT_PORT_L, 13'h0);
    chk(acc_wr, 5'h13);
    run(sibd_pkg::OP_INPUT_PORT_D_TO_CARRY, 13'h0);
    chk(carry_flag, 1'b0);
    @(posedge clock) core.acc <= 4'h3;
    run(sibd_pkg::OP_LOAD_VOLTAGE_PWM, 13'h2);
    run(sibd_pkg::OP_LOAD_DA_LATCH, 13'h0);
    chk(voltage_pwm_out[2], 7'h53);
    chk(da_latch, 15'h7ABC);
    run(sibd_pkg::OP_SILENCE_SET, 13'h0);
    ck();
    chk(voltage_pwm_out[2], 7'h00);
    run(sibd_pkg::OP_SILENCE_CANCEL, 13'h0);
    ck();
    chk(voltage_pwm_out[2], 7'h53);
    $display("ports done");
  endtask
  task automatic t_flow();
    run(sibd_pkg::OP_LONG_JUMP, 13'h1234);
    chk(pc, 13'h1234);
    run(sibd_pkg::OP_PAGE_JUMP, 13'h1ABC);
    chk(pc, 13'h0ABC);
    run(sibd_pkg::OP_LONG_CALL, 13'h0100);
    chk(pc, 13'h0100);
    run(sibd_pkg::OP_RETURN_SUBROUTINE, 13'h0);
    chk(pc, 13'h0040);
    run(sibd_pkg::OP_PAGE_CALL, 13'h0200);
    run(sibd_pkg::OP_RETURN_AND_SKIP, 13'h0);
    chk({pc, skip_flag}, 14'h0081);
    run(sibd_pkg::OP_NOP, 13'h0);
    run(sibd_pkg::OP_FORCED_SKIP, 13'h0);
    chk(skip_flag, 1'b1);
    run(sibd_pkg::OP_INTERRUPT_ENABLE, 13'h0);
    chk(interrupt_enable_flag, 1'b0);
    run(sibd_pkg::OP_INTERRUPT_ENABLE, 13'h0);
    chk(interrupt_enable_flag, 1'b1);
    run(sibd_pkg::OP_INTERRUPT_DISABLE, 13'h0);
    chk(interrupt_enable_flag, 1'b0);
    // interrupt entry while a skip is pending, so the return must bring it back
    run(sibd_pkg::OP_FORCED_SKIP, 13'h0);
    @(posedge clock) irq_take <= 1'b1;
    @(posedge clock) irq_take <= 1'b0;
    run(sibd_pkg::OP_RETURN_FROM_INTERRUPT, 13'h0);
    chk({pc, skip_flag}, 14'h0081);
    run(sibd_pkg::OP_NOP, 13'h0);
    rd(sibd_pkg::REG_PC, 16'h0040);
    rd(8'h40, 16'h0);
    $display("flow done");
  endtask
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    ck();
    t_carry();
    t_cmp();
    t_occ();
    t_io();
    t_flow();
    end_sim();
  end
endmodule
